// >>> include/core_state_pkg.sv
// Package with constants for the CPU core state block
// Contract
// - ALU single-cycle access to all 32 registers
// - Flags updated after every ALU operation
// - Flags at 0x5F, I/O 0x3F, reset zero
// - I/O address is data address minus 0x20
// - Bit 7 zero disables all interrupts
// - Interrupt entry clears, return sets enable
// - Bit 6 copy store for bit instructions
// - Sign flag equals negative xor overflow
// - Fixed flag bit positions H V N Z C
// - Four register file port schemes
// - Registers mapped at data 0x00 to 0x1F
// - Registers 26 to 31 form three pointers
// - Pointers support displacement, increment, decrement
// - Stack grows down, push decrements by 1
// - Calls and interrupt entry decrement by 2
// - Pop increments by 1, returns by 2
// - Stack pointer resets to 0x4FF
// - Stack bits 10..0 writable, upper read zero
// - Stack low at 0x5D, high at 0x5E
// - Extended range from 0x60 load/store only
// - 16-bit write: low to temp, high commits
// - 16-bit read: low latches high to temp
package core_state_pkg;
    localparam logic [15:0] ADDR_SP_LOW     = 16'h005D;
    localparam logic [15:0] ADDR_SP_HIGH    = 16'h005E;
    localparam logic [15:0] ADDR_FLAGS      = 16'h005F;
    localparam logic [15:0] ADDR_REGS_END   = 16'h001F;
    localparam logic [15:0] ADDR_EXT_START  = 16'h0060;
    localparam logic [5:0]  IO_FLAGS        = 6'h3F;
    localparam logic [15:0] IO_TO_DATA      = 16'h0020;
    localparam logic [7:0]  FLAGS_RESET     = 8'h00;
    localparam logic [15:0] SP_RESET        = 16'h04FF;
    localparam logic [15:0] SP_MASK         = 16'h07FF;
    localparam int          BIT_IE          = 7;
    localparam int          BIT_COPY        = 6;
    localparam int          BIT_HALF        = 5;
    localparam int          BIT_SIGN        = 4;
    localparam int          BIT_OVF         = 3;
    localparam int          BIT_NEG         = 2;
    localparam int          BIT_ZERO        = 1;
    localparam int          BIT_CARRY       = 0;
    localparam logic [4:0]  REG_PTR_X       = 5'h1A;
    localparam logic [4:0]  REG_PTR_Y       = 5'h1C;
    localparam logic [4:0]  REG_PTR_Z       = 5'h1E;

    // Stack pointer operations
    typedef enum logic [5:0] {
        SP_HOLD     = 6'b000001,
        SP_PUSH     = 6'b000010,
        SP_POP      = 6'b000100,
        SP_CALL     = 6'b001000,
        SP_RET      = 6'b010000,
        SP_RETURN_FROM_INTERRUPT     = 6'b100000
    } sp_op_t;

    // Pointer access modes
    typedef enum logic [3:0] {
        PTR_PLAIN   = 4'b0001,
        PTR_POSTINC = 4'b0010,
        PTR_PREDEC  = 4'b0100,
        PTR_DISP    = 4'b1000
    } ptr_mode_t;
endpackage

// >>> rtl/core_state.sv
// CPU flags, working register file, pointers and stack pointer
`timescale 1ns/1ps
`default_nettype none
module core_state
    import core_state_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    // Operand read ports
    input  wire logic [4:0]  rd_addr_a,
    input  wire logic [4:0]  rd_addr_b,
    output logic [7:0]       rd_data_a,
    output logic [7:0]       rd_data_b,
    output logic [15:0]      rd_pair_a,
    // Result write port
    input  wire logic        res_we,
    input  wire logic        res_wide,
    input  wire logic [4:0]  res_addr,
    input  wire logic [15:0] res_data,
    // ALU flag update
    input  wire logic        alu_flag_we,
    input  wire logic [7:0]  alu_flag_mask,
    input  wire logic [7:0]  alu_flags,
    // Interrupt enable control
    input  wire logic        irq_taken,
    input  wire logic        ie_set,
    input  wire logic        ie_clear,
    input  wire logic        irq_pending,
    output logic             irq_request,
    // Bit copy instructions
    input  wire logic        bit_store_to_copy,
    input  wire logic        bit_load_from_copy,
    input  wire logic [4:0]  bit_reg,
    input  wire logic [2:0]  bit_sel,
    // Indirect pointer update
    input  wire logic        ptr_use,
    input  wire logic [1:0]  ptr_sel,
    input  wire ptr_mode_t   ptr_mode,
    input  wire logic [5:0]  ptr_disp,
    output logic [15:0]      ptr_addr,
    // Stack pointer
    input  wire sp_op_t      sp_op,
    output logic [15:0]      stack_top_pointer,
    // Data and I/O space access
    input  wire logic        dbus_io,
    input  wire logic [15:0] dbus_addr,
    input  wire logic        dbus_rd,
    input  wire logic        dbus_wr,
    input  wire logic [7:0]  dbus_wdata,
    output logic [7:0]       dbus_rdata,
    output logic             dbus_hit,
    output logic [7:0]       processor_flags
);

    logic [7:0]  regs_r [32];
    logic [7:0]  flags_r;
    logic [15:0] sp_r;
    logic [7:0]  temp_r;
    logic [15:0] eff_addr;
    logic        hit_regs;
    logic        hit_flags;
    logic        hit_spl;
    logic        hit_sph;
    logic [4:0]  ptr_lo;
    logic [15:0] ptr_val;
    logic [15:0] ptr_new;
    logic [7:0]  flags_nxt;
    logic [15:0] sp_nxt;

    //--------------------------------------------------------------
    // Address decode
    //--------------------------------------------------------------
    // I/O numbers reach only the 64 locations below the extended range
    assign eff_addr  = dbus_io ? ({10'h000, dbus_addr[5:0]} + IO_TO_DATA)
                               : dbus_addr;
    assign hit_regs  = !dbus_io && (eff_addr <= ADDR_REGS_END);
    assign hit_flags = (eff_addr == ADDR_FLAGS);
    assign hit_spl   = (eff_addr == ADDR_SP_LOW);
    assign hit_sph   = (eff_addr == ADDR_SP_HIGH);
    assign dbus_hit  = hit_regs || hit_flags || hit_spl || hit_sph;

    //--------------------------------------------------------------
    // Register file and pointers
    //--------------------------------------------------------------
    assign rd_data_a = regs_r[rd_addr_a];
    assign rd_data_b = regs_r[rd_addr_b];
    assign rd_pair_a = {regs_r[{rd_addr_a[4:1], 1'b1}],
                        regs_r[{rd_addr_a[4:1], 1'b0}]};

    always_comb
    begin
        case (ptr_sel)
            2'd0:    ptr_lo = REG_PTR_X;
            2'd1:    ptr_lo = REG_PTR_Y;
            default: ptr_lo = REG_PTR_Z;
        endcase
    end

    assign ptr_val = {regs_r[ptr_lo + 5'd1], regs_r[ptr_lo]};

    always_comb
    begin
        ptr_new  = ptr_val;
        ptr_addr = ptr_val;
        case (ptr_mode)
            PTR_POSTINC: ptr_new = ptr_val + 16'h0001;
            PTR_PREDEC:
            begin
                ptr_new  = ptr_val - 16'h0001;
                ptr_addr = ptr_new;
            end
            PTR_DISP:    ptr_addr = ptr_val + {10'h000, ptr_disp};
            default:     ptr_new = ptr_val;
        endcase
    end

    // Later writes in this block take priority over earlier ones
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++)
        begin : g_reg
            always_ff @(posedge clk)
            begin
                if (reset)
                    regs_r[gi] <= 8'h00;
                else
                begin
                    if (ptr_use && (ptr_mode == PTR_POSTINC
                        || ptr_mode == PTR_PREDEC))
                    begin
                        if (gi == ptr_lo)
                            regs_r[gi] <= ptr_new[7:0];
                        if (gi == ptr_lo + 5'd1)
                            regs_r[gi] <= ptr_new[15:8];
                    end
                    if (dbus_wr && hit_regs && eff_addr[4:0] == gi)
                        regs_r[gi] <= dbus_wdata;
                    if (bit_load_from_copy && bit_reg == gi)
                        regs_r[gi][bit_sel] <= flags_r[BIT_COPY];
                    if (res_we && res_wide && res_addr[4:1] == gi / 2)
                        regs_r[gi] <= (gi % 2 == 1) ? res_data[15:8]
                                                    : res_data[7:0];
                    if (res_we && !res_wide && res_addr == gi)
                        regs_r[gi] <= res_data[7:0];
                end
            end
        end
    endgenerate

    //--------------------------------------------------------------
    // Flags register
    //--------------------------------------------------------------
    always_comb
    begin
        flags_nxt = flags_r;
        if (alu_flag_we)
        begin
            flags_nxt = (flags_r & ~alu_flag_mask)
                      | (alu_flags & alu_flag_mask);
            if (alu_flag_mask[BIT_NEG] || alu_flag_mask[BIT_OVF])
                flags_nxt[BIT_SIGN] = flags_nxt[BIT_NEG]
                                    ^ flags_nxt[BIT_OVF];
        end
        if (bit_store_to_copy)
            flags_nxt[BIT_COPY] = regs_r[bit_reg][bit_sel];
        if (dbus_wr && hit_flags)
            flags_nxt = dbus_wdata;
        if (ie_clear || irq_taken)
            flags_nxt[BIT_IE] = 1'b0;
        if (ie_set || sp_op == SP_RETURN_FROM_INTERRUPT)
            flags_nxt[BIT_IE] = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            flags_r <= FLAGS_RESET;
        else
            flags_r <= flags_nxt;
    end

    assign processor_flags = flags_r;
    assign irq_request = irq_pending && flags_r[BIT_IE];

    //--------------------------------------------------------------
    // Stack pointer and 16-bit temporary
    //--------------------------------------------------------------
    always_comb
    begin
        case (sp_op)
            SP_PUSH: sp_nxt = sp_r - 16'h0001;
            SP_CALL: sp_nxt = sp_r - 16'h0002;
            SP_POP:  sp_nxt = sp_r + 16'h0001;
            SP_RET:  sp_nxt = sp_r + 16'h0002;
            SP_RETURN_FROM_INTERRUPT: sp_nxt = sp_r + 16'h0002;
            default: sp_nxt = sp_r;
        endcase
        if (dbus_wr && hit_sph)
            sp_nxt = {dbus_wdata, temp_r};
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            sp_r <= SP_RESET;
        else
            sp_r <= sp_nxt & SP_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            temp_r <= 8'h00;
        else if (dbus_wr && hit_spl)
            temp_r <= dbus_wdata;
        else if (dbus_rd && hit_spl)
            temp_r <= sp_r[15:8];
    end

    assign stack_top_pointer = sp_r;

    //--------------------------------------------------------------
    // Read data
    //--------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
            dbus_rdata <= 8'h00;
        else if (dbus_rd)
        begin
            if (hit_regs)
                dbus_rdata <= regs_r[eff_addr[4:0]];
            else if (hit_flags)
                dbus_rdata <= flags_r;
            else if (hit_spl)
                dbus_rdata <= sp_r[7:0];
            else if (hit_sph)
                dbus_rdata <= temp_r;
            else
                dbus_rdata <= 8'h00;
        end
    end

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    property p_flags_reset;
        @(posedge clk) $fell(reset) |-> processor_flags == 8'h00;
    endproperty
    a_flags_reset: assert property (p_flags_reset)
        else $error("flags not zero after reset");

    property p_sp_reset;
        @(posedge clk) $fell(reset) |-> stack_top_pointer == 16'h04FF;
    endproperty
    a_sp_reset: assert property (p_sp_reset)
        else $error("stack pointer reset value wrong");

    property p_push;
        @(posedge clk) disable iff (reset)
        (sp_op == SP_PUSH && !(dbus_wr && hit_sph))
        |=> stack_top_pointer == (($past(stack_top_pointer) - 16'h0001)
                                  & 16'h07FF);
    endproperty
    a_push: assert property (p_push)
        else $error("push did not decrement by one");

    property p_call;
        @(posedge clk) disable iff (reset)
        (sp_op == SP_CALL && !(dbus_wr && hit_sph))
        |=> stack_top_pointer == (($past(stack_top_pointer) - 16'h0002)
                                  & 16'h07FF);
    endproperty
    a_call: assert property (p_call)
        else $error("call did not decrement by two");

    property p_ret;
        @(posedge clk) disable iff (reset)
        ((sp_op == SP_RET || sp_op == SP_RETURN_FROM_INTERRUPT) && !(dbus_wr && hit_sph))
        |=> stack_top_pointer == (($past(stack_top_pointer) + 16'h0002)
                                  & 16'h07FF);
    endproperty
    a_ret: assert property (p_ret)
        else $error("return did not increment by two");

    property p_sp_upper;
        @(posedge clk) disable iff (reset) stack_top_pointer[15:11] == 5'h00;
    endproperty
    a_sp_upper: assert property (p_sp_upper)
        else $error("stack pointer upper bits set");

    property p_ie_gate;
        @(posedge clk) disable iff (reset)
        !processor_flags[7] |-> !irq_request;
    endproperty
    a_ie_gate: assert property (p_ie_gate)
        else $error("interrupt requested while disabled");

    property p_irq_clear;
        @(posedge clk) disable iff (reset)
        (irq_taken && !ie_set && sp_op != SP_RETURN_FROM_INTERRUPT) |=> !processor_flags[7];
    endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("enable not cleared on interrupt");

    property p_sign;
        @(posedge clk) disable iff (reset)
        (alu_flag_we && alu_flag_mask[2] && alu_flag_mask[3]
         && !(dbus_wr && hit_flags))
        |=> processor_flags[4] == (processor_flags[2] ^ processor_flags[3]);
    endproperty
    a_sign: assert property (p_sign)
        else $error("sign flag not n xor v");

    property p_wide_write;
        @(posedge clk) disable iff (reset)
        (dbus_wr && hit_spl) ##1 (dbus_wr && hit_sph && sp_op == SP_HOLD)
        |=> stack_top_pointer[7:0] == $past(dbus_wdata, 2);
    endproperty
    a_wide_write: assert property (p_wide_write)
        else $error("low byte not committed from temp");

    property p_wide_read;
        @(posedge clk) disable iff (reset)
        (dbus_rd && !dbus_wr && hit_spl) ##1 (dbus_rd && hit_sph)
        |=> {dbus_rdata, 8'h00} == ($past(stack_top_pointer, 2) & 16'hFF00);
    endproperty
    a_wide_read: assert property (p_wide_read)
        else $error("high byte not returned from temp");

    property p_postinc;
        @(posedge clk) disable iff (reset)
        (ptr_use && ptr_mode == PTR_POSTINC && ptr_sel == 2'd0
         && !res_we && !dbus_wr && !bit_load_from_copy)
        |=> {regs_r[REG_PTR_X + 5'd1], regs_r[REG_PTR_X]}
            == $past(ptr_val) + 16'h0001;
    endproperty
    a_postinc: assert property (p_postinc)
        else $error("pointer post-increment wrong");

    property p_copy_store;
        @(posedge clk) disable iff (reset)
        (bit_store_to_copy && regs_r[bit_reg][bit_sel]
         && !(dbus_wr && hit_flags))
        |=> processor_flags[BIT_COPY];
    endproperty
    a_copy_store: assert property (p_copy_store)
        else $error("copy bit not stored");

    c_push: cover property (@(posedge clk) sp_op == SP_PUSH);
    c_return_from_interrupt: cover property (@(posedge clk) sp_op == SP_RETURN_FROM_INTERRUPT);
    c_wide: cover property (@(posedge clk) (dbus_rd && hit_spl)
                            ##1 (dbus_rd && hit_sph));

endmodule // core_state
`default_nettype wire

// >>> verification/core_state_tb_top.sv
// Self-checking testbench for the CPU core state block
`timescale 1ns/1ps
`default_nettype none
module core_state_tb_top
    import core_state_pkg::*;
;
    logic        clk, reset, res_we, res_wide, alu_flag_we, irq_taken;
    logic        ie_set, ie_clear, irq_pending, irq_request, h, ptr_use;
    logic        bit_store_to_copy, bit_load_from_copy, dbus_io, dbus_rd;
    logic        dbus_wr, dbus_hit;
    logic [4:0]  rd_addr_a, rd_addr_b, res_addr, bit_reg;
    logic [7:0]  rd_data_a, rd_data_b, alu_flag_mask, alu_flags, d;
    logic [7:0]  dbus_wdata, dbus_rdata, processor_flags;
    logic [15:0] rd_pair_a, res_data, ptr_addr, stack_top_pointer;
    logic [15:0] dbus_addr, e;
    logic [2:0]  bit_sel;
    logic [1:0]  ptr_sel;
    logic [5:0]  ptr_disp;
    ptr_mode_t   ptr_mode;
    sp_op_t      sp_op;
    int          n_errors, checked;

    core_state u_dut (.clk(clk), .reset(reset), .rd_addr_a(rd_addr_a),
        .rd_addr_b(rd_addr_b), .rd_data_a(rd_data_a),
        .rd_data_b(rd_data_b), .rd_pair_a(rd_pair_a), .res_we(res_we),
        .res_wide(res_wide), .res_addr(res_addr), .res_data(res_data),
        .alu_flag_we(alu_flag_we), .alu_flag_mask(alu_flag_mask),
        .alu_flags(alu_flags), .irq_taken(irq_taken), .ie_set(ie_set),
        .ie_clear(ie_clear), .irq_pending(irq_pending),
        .irq_request(irq_request), .bit_store_to_copy(bit_store_to_copy),
        .bit_load_from_copy(bit_load_from_copy), .bit_reg(bit_reg),
        .bit_sel(bit_sel), .ptr_use(ptr_use), .ptr_sel(ptr_sel),
        .ptr_mode(ptr_mode), .ptr_disp(ptr_disp), .ptr_addr(ptr_addr),
        .sp_op(sp_op), .stack_top_pointer(stack_top_pointer),
        .dbus_io(dbus_io), .dbus_addr(dbus_addr), .dbus_rd(dbus_rd),
        .dbus_wr(dbus_wr), .dbus_wdata(dbus_wdata),
        .dbus_rdata(dbus_rdata), .dbus_hit(dbus_hit),
        .processor_flags(processor_flags));

    sw_model u_sw (.clk(clk), .dbus_rdata(dbus_rdata), .dbus_hit(dbus_hit),
        .dbus_io(dbus_io), .dbus_addr(dbus_addr), .dbus_rd(dbus_rd),
        .dbus_wr(dbus_wr), .dbus_wdata(dbus_wdata));

    task automatic test_done;
        if (n_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic t_reset;
        u_sw.rd(1'b0, ADDR_FLAGS, d, h);
        chk({8'h00, d}, 16'h0000);
        chk(stack_top_pointer, 16'h04FF);
        u_sw.rd(1'b0, 16'h005D, d, h);
        chk({8'h00, d}, 16'h00FF);
        u_sw.rd(1'b0, 16'h005E, d, h);
        chk({8'h00, d}, 16'h0004);
    endtask

    task automatic t_stack;
        sp_op_t ops[5];
        int     dl[5];
        ops = '{SP_PUSH, SP_CALL, SP_POP, SP_RET, SP_RETURN_FROM_INTERRUPT};
        dl  = '{-1, -2, 1, 2, 2};
        u_sw.wr(1'b0, 16'h005D, 8'h34);
        chk(stack_top_pointer, 16'h04FF);
        u_sw.wr(1'b0, 16'h005E, 8'hFF);
        chk(stack_top_pointer, 16'h0734);
        u_sw.rd(1'b1, 16'h003D, d, h);
        chk({8'h00, d}, 16'h0034);
        u_sw.rd(1'b1, 16'h003E, d, h);
        chk({8'h00, d}, 16'h0007);
        e = 16'h0734;
        for (int i = 0; i < 5; i++)
        begin
            @(negedge clk);
            sp_op = ops[i];
            @(negedge clk);
            sp_op = SP_HOLD;
            e = 16'(int'(e) + dl[i]);
            chk(stack_top_pointer, e);
        end
        chk({15'h0000, processor_flags[7]}, 16'h0001);
        u_sw.wr16(1'b1, 16'h003D, 16'hF9AB);
        chk(stack_top_pointer, 16'h01AB);
        u_sw.rd16(1'b0, ADDR_SP_LOW, e);
        chk(e, 16'h01AB);
    endtask

    task automatic t_flags;
        logic [7:0] v[3];
        logic [7:0] x[3];
        v = '{8'h04, 8'h0C, 8'h23};
        x = '{8'h54, 8'h4C, 8'h63};
        u_sw.wr(1'b0, ADDR_FLAGS, 8'h5A);
        u_sw.rd(1'b1, 16'h003F, d, h);
        chk({8'h00, d}, 16'h005A);
        alu_flag_mask = 8'h3F;
        for (int i = 0; i < 3; i++)
        begin
            @(negedge clk);
            alu_flag_we = 1'b1;
            alu_flags   = v[i];
            @(negedge clk);
            alu_flag_we = 1'b0;
            chk(16'(processor_flags), 16'(x[i]));
        end
    endtask

    task automatic t_irq;
        logic [7:0] sv;
        irq_pending = 1'b1;
        u_sw.rd(1'b0, ADDR_FLAGS, sv, h);
        u_sw.wr(1'b0, ADDR_FLAGS, 8'h00);
        chk({15'h0000, irq_request}, 16'h0000);
        ie_set = 1'b1;
        @(negedge clk);
        ie_set = 1'b0;
        chk({15'h0000, irq_request}, 16'h0001);
        chk({15'h0000, processor_flags[7]}, 16'h0001);
        irq_taken = 1'b1;
        @(negedge clk);
        irq_taken = 1'b0;
        chk({14'h0000, irq_request, processor_flags[7]}, 16'h0000);
        u_sw.wr(1'b0, ADDR_FLAGS, sv);
        chk({8'h00, processor_flags}, {8'h00, sv});
    endtask

    task automatic t_regs;
        @(negedge clk);
        {res_we, res_addr, res_data} = {1'b1, 5'h05, 16'h0008};
        @(negedge clk);
        {res_wide, res_addr, res_data} = {1'b1, 5'h1A, 16'h0123};
        @(negedge clk);
        {res_we, res_wide, rd_addr_a, rd_addr_b} = {2'b00, 5'h1A, 5'h1B};
        #1;
        chk(rd_pair_a, 16'h0123);
        chk({8'h00, rd_data_b}, 16'h0001);
        @(negedge clk);
        rd_addr_a = 5'h05;
        #1;
        chk({8'h00, rd_data_a}, 16'h0008);
        u_sw.rd(1'b0, 16'h0005, d, h);
        chk({8'h00, d}, 16'h0008);
        chk({15'h0000, h}, 16'h0001);
        u_sw.rd(1'b1, 16'h0005, d, h);
        chk({8'h00, d}, 16'h0000);
        u_sw.rd(1'b0, ADDR_EXT_START, d, h);
        chk({15'h0000, h}, 16'h0000);
    endtask

    task automatic t_ptr;
        ptr_mode_t  m[3];
        logic [15:0] pa[3];
        logic [15:0] pr[3];
        m  = '{PTR_POSTINC, PTR_PREDEC, PTR_DISP};
        pa = '{16'h0123, 16'h0123, 16'h0128};
        pr = '{16'h0124, 16'h0123, 16'h0123};
        {ptr_sel, ptr_disp, rd_addr_a} = {2'b00, 6'h05, 5'h1A};
        for (int i = 0; i < 3; i++)
        begin
            @(negedge clk);
            ptr_use  = 1'b1;
            ptr_mode = m[i];
            #1;
            chk(ptr_addr, pa[i]);
            @(negedge clk);
            ptr_use = 1'b0;
            #1;
            chk(rd_pair_a, pr[i]);
        end
        @(negedge clk);
        {ptr_sel, rd_addr_a, ptr_use} = {2'd1, 5'h1C, 1'b1};
        ptr_mode = PTR_PREDEC;
        #1;
        chk(ptr_addr, 16'hFFFF);
        @(negedge clk);
        ptr_use = 1'b0;
        #1;
        chk(rd_pair_a, 16'hFFFF);
    endtask

    task automatic t_bits;
        u_sw.wr(1'b0, ADDR_FLAGS, 8'h00);
        {bit_store_to_copy, bit_reg, bit_sel} = {1'b1, 5'h05, 3'h3};
        @(negedge clk);
        {bit_store_to_copy, bit_load_from_copy} = 2'b01;
        {bit_reg, bit_sel, rd_addr_b} = {5'h06, 3'h1, 5'h06};
        chk({8'h00, processor_flags}, 16'h0040);
        @(negedge clk);
        bit_load_from_copy = 1'b0;
        chk({8'h00, rd_data_b}, 16'h0002);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        test_done();
    end

    initial
    begin
        {reset, res_we, res_wide, alu_flag_we, irq_taken, ie_set} = 6'h20;
        {ie_clear, irq_pending, ptr_use, ptr_sel, ptr_disp} = 11'h000;
        {bit_store_to_copy, bit_load_from_copy, bit_reg, bit_sel} = 10'h000;
        {rd_addr_a, rd_addr_b, res_addr, res_data} = 31'h0;
        {alu_flag_mask, alu_flags} = 16'h0000;
        ptr_mode = PTR_PLAIN;
        sp_op    = SP_HOLD;
        repeat (12) @(negedge clk);
        reset = 1'b0;
        t_reset();
        t_stack();
        t_flags();
        t_irq();
        t_regs();
        t_ptr();
        t_bits();
        test_done();
    end
endmodule // core_state_tb_top
`default_nettype wire

// >>> verification/sw_model.sv
// Program software model issuing data and I/O space accesses
`timescale 1ns/1ps
`default_nettype none
module sw_model
(
    input  wire logic        clk,
    input  wire logic [7:0]  dbus_rdata,
    input  wire logic        dbus_hit,
    output logic             dbus_io,
    output logic [15:0]      dbus_addr,
    output logic             dbus_rd,
    output logic             dbus_wr,
    output logic [7:0]       dbus_wdata
);
    initial
    begin
        {dbus_io, dbus_rd, dbus_wr} = 3'b000;
        dbus_addr  = 16'h00AA;
        dbus_wdata = 8'h55;
    end
    // Idle bus shows inverted leftovers, never the last access
    task automatic wr(input logic io, input logic [15:0] a,
                      input logic [7:0] d);
        @(negedge clk);
        {dbus_io, dbus_addr, dbus_wdata, dbus_wr} = {io, a, d, 1'b1};
        @(negedge clk);
        {dbus_addr, dbus_wdata, dbus_wr} = {~a, ~d, 1'b0};
    endtask
    task automatic rd(input logic io, input logic [15:0] a,
                      output logic [7:0] d, output logic h);
        @(negedge clk);
        {dbus_io, dbus_addr, dbus_rd} = {io, a, 1'b1};
        #1;
        h = dbus_hit;
        @(negedge clk);
        d = dbus_rdata;
        {dbus_addr, dbus_rd} = {~a, 1'b0};
    endtask
    // Back-to-back 16-bit accesses, low byte first
    task automatic wr16(input logic io, input logic [15:0] a,
                        input logic [15:0] v);
        @(negedge clk);
        {dbus_io, dbus_addr, dbus_wdata, dbus_wr} = {io, a, v[7:0], 1'b1};
        @(negedge clk);
        {dbus_addr, dbus_wdata} = {a + 16'h0001, v[15:8]};
        @(negedge clk);
        {dbus_addr, dbus_wdata, dbus_wr} = {~a, ~v[15:8], 1'b0};
    endtask
    task automatic rd16(input logic io, input logic [15:0] a,
                        output logic [15:0] v);
        @(negedge clk);
        {dbus_io, dbus_addr, dbus_rd} = {io, a, 1'b1};
        @(negedge clk);
        v[7:0] = dbus_rdata;
        dbus_addr = a + 16'h0001;
        @(negedge clk);
        v[15:8] = dbus_rdata;
        {dbus_addr, dbus_rd} = {~a, 1'b0};
    endtask
endmodule // sw_model
`default_nettype wire
